/* File: rtl/lcts_defines.svh */
// constants for the second link controller status block
`ifndef LCTS_DEFINES_SVH
`define LCTS_DEFINES_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define LCTS_ADDR_W 4
`define LCTS_OFF_STATUS 4'h0
`define LCTS_OFF_ENABLE 4'h1
`define LCTS_OFF_CLEAR 4'h2
`define LCTS_OFF_KIND 4'h3

// ----------------------------------------
// status bit positions
// ----------------------------------------
`define LCTS_BIT_KIND 7
`define LCTS_BIT_TXSTART 6
`define LCTS_BIT_RXSTART 5
`define LCTS_BIT_TXEND 4
`define LCTS_BIT_RXEND 3
`define LCTS_BIT_FCSERR 2
`define LCTS_BIT_ABORT 1
`define LCTS_BIT_FLAGSEEN 0
`define LCTS_NEVT 7
`define LCTS_RESET_VAL 8'h00
`define LCTS_EVT_ZERO 7'h00

`endif

/* File: rtl/lcts_pkg.sv */
// types for the second link controller status block
package lcts_pkg;
  // message kind encoding
  typedef enum logic {
    LCTS_KIND_BIT_ORIENTED,
    LCTS_KIND_MSG_ORIENTED
  } lcts_kind_t;
  // access kind seen on the port
  typedef enum logic [1:0] {
    LCTS_ACC_IDLE,
    LCTS_ACC_READ,
    LCTS_ACC_WRITE
  } lcts_acc_t;
endpackage

/* File: rtl/lcts_evt_if.sv */
// event carrier between the top and the sticky flag bank
`timescale 1ns/1ps
`default_nettype none
`include "lcts_defines.svh"
interface lcts_evt_if;
  logic [`LCTS_NEVT-1:0] setPulse; // event pulses
  logic [`LCTS_NEVT-1:0] clrMask; // bits to clear this cycle
  logic [`LCTS_NEVT-1:0] flags; // sticky flags
  modport bank (input setPulse, input clrMask, output flags);
  modport ctrl (output setPulse, output clrMask, input flags);
endinterface
`default_nettype wire

/* File: rtl/lcts_flag_bank.sv */
// sticky event flags: set wins over clear
`timescale 1ns/1ps
`default_nettype none
`include "lcts_defines.svh"
module lcts_flag_bank (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // event carrier
  lcts_evt_if.bank evt
);
  // ----------------------------------------
  // one sticky flip-flop per event
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < `LCTS_NEVT; i++) begin : gFlag
      logic flag_q; // sticky state
      // set beats a clear in the same cycle
      always_ff @(posedge clock) begin
        if (rst) begin
          flag_q <= 1'b0;
        end else if (evt.setPulse[i]) begin
          flag_q <= 1'b1;
        end else if (evt.clrMask[i]) begin
          flag_q <= 1'b0;
        end
      end
      assign evt.flags[i] = flag_q;
    end
  endgenerate
endmodule
`default_nettype wire

/* File: rtl/lcts_status.sv */
// status register bank for the second link controller
// Behaviour
// - bit 7 shows last received message kind
// - bit 6 set at transmit message start
// - bit 5 set at receive message start
// - bit 4 set at transmit message end
// - bit 3 set at receive end or buffer full
// - bit 2 set on frame check error
// - bit 1 set on seven-ones abort
// - bit 0 set on flag octet seen
// - flags hold until a status read or clear write clears them
// - flag seen plus end means whole message
// - enable bit gates each event onto interrupt
//
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "lcts_defines.svh"
module lcts_status (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // register port
  input wire logic [`LCTS_ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  // controller events, one-cycle pulses
  input wire logic txStartEvt,
  input wire logic rxStartEvt,
  input wire logic txEndEvt,
  input wire logic rxEndEvt,
  input wire logic rxBufFullEvt,
  input wire logic fcsErrEvt,
  input wire logic abortEvt,
  input wire logic flagOctetEvt,
  // message kind of the message just received
  input wire logic rxMsgDoneEvt,
  input wire logic rxMsgKind,
  // interrupt and whole-message indication
  output logic irq,
  output logic wholeMsg
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  lcts_evt_if evt (); // carrier to the flag bank
  lcts_pkg::lcts_kind_t kind_q; // last message kind
  logic [`LCTS_NEVT-1:0] enable_q; // interrupt enables
  logic [7:0] rdData_q; // registered read data
  logic [7:0] statusView; // assembled status byte
  lcts_pkg::lcts_acc_t acc; // decoded access

  // ----------------------------------------
  // access decode
  // ----------------------------------------
  // one access kind per cycle for the clear decode; a read wins should both strobes appear, but an enable write still lands
  always_comb begin
    if (regRd) begin
      acc = lcts_pkg::LCTS_ACC_READ;
    end else if (regWr) begin
      acc = lcts_pkg::LCTS_ACC_WRITE;
    end else begin
      acc = lcts_pkg::LCTS_ACC_IDLE;
    end
  end

  // ----------------------------------------
  // event mapping
  // ----------------------------------------
  // each controller event lands on its own sticky bit, except end and buffer full, which share bit 3
  // transmit start sets bit 6
  assign evt.setPulse[`LCTS_BIT_TXSTART] = txStartEvt;
  assign evt.setPulse[`LCTS_BIT_RXSTART] = rxStartEvt;
  assign evt.setPulse[`LCTS_BIT_TXEND] = txEndEvt;
  // end or buffer full sets bit 3
  assign evt.setPulse[`LCTS_BIT_RXEND] = rxEndEvt | rxBufFullEvt;
  // frame check error sets bit 2
  assign evt.setPulse[`LCTS_BIT_FCSERR] = fcsErrEvt;
  assign evt.setPulse[`LCTS_BIT_ABORT] = abortEvt;
  assign evt.setPulse[`LCTS_BIT_FLAGSEEN] = flagOctetEvt;

  // a clear hits only flags, never the kind bit or the enables
  // status read or clear write resets flags
  always_comb begin
    evt.clrMask = `LCTS_EVT_ZERO;
    unique case (acc)
      lcts_pkg::LCTS_ACC_READ: begin
        if (regAddr == `LCTS_OFF_STATUS) begin
          evt.clrMask = ~`LCTS_EVT_ZERO;
        end
      end
      lcts_pkg::LCTS_ACC_WRITE: begin
        if (regAddr == `LCTS_OFF_CLEAR) begin
          evt.clrMask = regWrData[`LCTS_NEVT-1:0];
        end
      end
      lcts_pkg::LCTS_ACC_IDLE: begin
        evt.clrMask = `LCTS_EVT_ZERO;
      end
    endcase
  end

  // sticky flag storage
  lcts_flag_bank uBank (
    .clock(clock),
    .rst(rst),
    .evt(evt.bank)
  );

  // ----------------------------------------
  // message kind
  // ----------------------------------------
  // kind holds until the next message ends, reads leave it alone
  // capture kind of each received message
  always_ff @(posedge clock) begin
    if (rst) begin
      kind_q <= lcts_pkg::LCTS_KIND_BIT_ORIENTED;
    end else if (rxMsgDoneEvt) begin
      kind_q <= lcts_pkg::lcts_kind_t'(rxMsgKind);
    end
  end

  // ----------------------------------------
  // enable register
  // ----------------------------------------
  // software writes the enables
  // bit 7 has no enable and always reads back as zero
  always_ff @(posedge clock) begin
    if (rst) begin
      enable_q <= `LCTS_EVT_ZERO;
    end else if (regWr && regAddr == `LCTS_OFF_ENABLE) begin
      enable_q <= regWrData[`LCTS_NEVT-1:0];
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  // kind in the top bit, sticky flags below it
  assign statusView = {kind_q, evt.flags};

  // read data stands one cycle after the strobe
  always_ff @(posedge clock) begin
    if (rst) begin
      rdData_q <= `LCTS_RESET_VAL;
    end else if (regRd) begin
      unique case (regAddr)
        `LCTS_OFF_STATUS: rdData_q <= statusView;
        `LCTS_OFF_ENABLE: rdData_q <= {1'b0, enable_q};
        `LCTS_OFF_KIND: rdData_q <= {7'h00, kind_q};
        default: rdData_q <= 8'h00;
      endcase
    end else begin
      rdData_q <= 8'h00;
    end
  end
  // read data leave straight from the flip-flop
  assign regRdData = rdData_q;

  // ----------------------------------------
  // interrupt
  // ----------------------------------------
  // level output, falls as soon as a read or clear empties the flags
  // enables gate events
  assign irq = |(evt.flags & enable_q);

  // flag seen with end marks whole message
  assign wholeMsg = evt.flags[`LCTS_BIT_FLAGSEEN] & evt.flags[`LCTS_BIT_RXEND];

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  // event-wide slice of the write data, for the write checks
  logic [`LCTS_NEVT-1:0] wrLow;
  assign wrLow = regWrData[`LCTS_NEVT-1:0];

  // transmit start pulse on its own
  sequence s_txStart;
    txStartEvt;
  endsequence
  // a read strobe aimed at the status register
  sequence s_statusRead;
    regRd && regAddr == `LCTS_OFF_STATUS;
  endsequence
  // a status read with no event arriving beside it
  sequence s_quietRead;
    s_statusRead ##0 !(|evt.setPulse);
  endsequence
  // a status read that meets at least one event
  sequence s_busyRead;
    s_statusRead ##0 (|evt.setPulse);
  endsequence
  // a write strobe aimed at the enable register
  sequence s_enableWrite;
    regWr && regAddr == `LCTS_OFF_ENABLE;
  endsequence
  // a clear write with no event arriving beside it
  sequence s_quietClear;
    regWr && regAddr == `LCTS_OFF_CLEAR && !(|evt.setPulse);
  endsequence
  // an enabled event while no write can move the enables
  sequence s_enabledEvent;
    (|(evt.setPulse & enable_q)) && !regWr;
  endsequence

  property p_txStartSets;
    @(posedge clock) disable iff (rst) s_txStart |=> statusView[`LCTS_BIT_TXSTART];
  endproperty
  a_txStartSets: assert property (p_txStartSets) else $error("tx start flag not set");

  property p_rxStartSets;
    @(posedge clock) disable iff (rst) rxStartEvt |=> statusView[`LCTS_BIT_RXSTART];
  endproperty
  a_rxStartSets: assert property (p_rxStartSets) else $error("rx start flag not set");

  property p_txEndSets;
    @(posedge clock) disable iff (rst) txEndEvt |=> statusView[`LCTS_BIT_TXEND];
  endproperty
  a_txEndSets: assert property (p_txEndSets) else $error("tx end flag not set");

  property p_rxEndSets;
    @(posedge clock) disable iff (rst) (rxEndEvt || rxBufFullEvt) |=> statusView[`LCTS_BIT_RXEND];
  endproperty
  a_rxEndSets: assert property (p_rxEndSets) else $error("rx end flag not set");

  property p_fcsSets;
    @(posedge clock) disable iff (rst) fcsErrEvt |=> statusView[`LCTS_BIT_FCSERR];
  endproperty
  a_fcsSets: assert property (p_fcsSets) else $error("fcs flag not set");

  property p_abortSets;
    @(posedge clock) disable iff (rst) abortEvt |=> statusView[`LCTS_BIT_ABORT];
  endproperty
  a_abortSets: assert property (p_abortSets) else $error("abort flag not set");

  property p_flagSeenSets;
    @(posedge clock) disable iff (rst) flagOctetEvt |=> statusView[`LCTS_BIT_FLAGSEEN];
  endproperty
  a_flagSeenSets: assert property (p_flagSeenSets) else $error("flag seen not set");

  property p_kindCapture;
    @(posedge clock) disable iff (rst)
      rxMsgDoneEvt |=> statusView[`LCTS_BIT_KIND] == $past(rxMsgKind);
  endproperty
  a_kindCapture: assert property (p_kindCapture) else $error("message kind wrong");

  property p_kindHolds;
    @(posedge clock) disable iff (rst) !rxMsgDoneEvt |=> $stable(kind_q);
  endproperty
  a_kindHolds: assert property (p_kindHolds) else $error("message kind moved");

  property p_readClears;
    @(posedge clock) disable iff (rst)
      (s_statusRead ##0 !txStartEvt) |=>
      regRdData == $past(statusView) && !statusView[`LCTS_BIT_TXSTART];
  endproperty
  a_readClears: assert property (p_readClears) else $error("read did not clear");

  property p_readClearsAll;
    @(posedge clock) disable iff (rst)
      s_quietRead |=> statusView[`LCTS_NEVT-1:0] == `LCTS_EVT_ZERO;
  endproperty
  a_readClearsAll: assert property (p_readClearsAll) else $error("flags left after read");

  property p_setBeatsRead;
    @(posedge clock) disable iff (rst)
      s_busyRead |=> (statusView[`LCTS_NEVT-1:0] & $past(evt.setPulse)) == $past(evt.setPulse);
  endproperty
  a_setBeatsRead: assert property (p_setBeatsRead) else $error("event lost beside read");

  property p_clearWrite;
    @(posedge clock) disable iff (rst)
      s_quietClear |=> (statusView[`LCTS_NEVT-1:0] & $past(wrLow)) == `LCTS_EVT_ZERO;
  endproperty
  a_clearWrite: assert property (p_clearWrite) else $error("clear write ignored");

  property p_rdIdle;
    @(posedge clock) disable iff (rst) !regRd |=> regRdData == `LCTS_RESET_VAL;
  endproperty
  a_rdIdle: assert property (p_rdIdle) else $error("read data outside read");

  property p_enableWrite;
    @(posedge clock) disable iff (rst) s_enableWrite |=> enable_q == $past(wrLow);
  endproperty
  a_enableWrite: assert property (p_enableWrite) else $error("enable write lost");

  property p_irqGate;
    @(posedge clock) disable iff (rst) s_enabledEvent |=> irq;
  endproperty
  a_irqGate: assert property (p_irqGate) else $error("interrupt not raised");

  property p_irqMasked;
    @(posedge clock) disable iff (rst) enable_q == `LCTS_EVT_ZERO |-> !irq;
  endproperty
  a_irqMasked: assert property (p_irqMasked) else $error("interrupt while masked");

  property p_irqNeedsFlag;
    @(posedge clock) disable iff (rst) irq |-> (|statusView[`LCTS_NEVT-1:0]);
  endproperty
  a_irqNeedsFlag: assert property (p_irqNeedsFlag) else $error("interrupt with no flag");

  property p_irqAfterRead;
    @(posedge clock) disable iff (rst) s_quietRead |=> !irq;
  endproperty
  a_irqAfterRead: assert property (p_irqAfterRead) else $error("irq held after read");

  property p_wholeMsg;
    @(posedge clock) disable iff (rst) (flagOctetEvt && rxEndEvt) |=> wholeMsg;
  endproperty
  a_wholeMsg: assert property (p_wholeMsg) else $error("whole message not shown");

  property p_wholeDrops;
    @(posedge clock) disable iff (rst) s_quietRead |=> !wholeMsg;
  endproperty
  a_wholeDrops: assert property (p_wholeDrops) else $error("whole message held");
endmodule
`default_nettype wire

/* File: dv/tb_top.sv */
// self-checking testbench for the link controller status block
`timescale 1ns/1ps
`default_nettype none
`include "lcts_defines.svh"
module tb_top;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic clock = 1'b0; // 40 MHz clock
  logic rst = 1'b1; // synchronous reset
  logic [`LCTS_ADDR_W-1:0] regAddr = 4'h0; // register index
  logic [7:0] regWrData = 8'h00; // write data
  logic regWr = 1'b0; // write strobe
  logic regRd = 1'b0; // read strobe
  logic [7:0] evt = 8'h00; // events by status bit, bit 7 is buffer full
  logic rxMsgDoneEvt = 1'b0; // message received
  logic rxMsgKind = 1'b0; // kind with it
  logic [7:0] regRdData; // read data
  logic irq; // interrupt level
  logic wholeMsg; // whole message level
  int errors = 0; // mismatch count
  int tests_run = 0; // comparison count

  // clock toggles every half period
  always #12.5 clock = ~clock;

  // ----------------------------------------
  // design under test
  // ----------------------------------------
  lcts_status u_dut (.clock(clock), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .txStartEvt(evt[6]),
    .rxStartEvt(evt[5]), .txEndEvt(evt[4]), .rxEndEvt(evt[3]), .rxBufFullEvt(evt[7]),
    .fcsErrEvt(evt[2]), .abortEvt(evt[1]), .flagOctetEvt(evt[0]),
    .rxMsgDoneEvt(rxMsgDoneEvt), .rxMsgKind(rxMsgKind), .irq(irq), .wholeMsg(wholeMsg));

  // ----------------------------------------
  // compare, bus and event tasks
  // ----------------------------------------
  // compare a byte
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t byte got %h exp %h", $time, got, exp);
    end
  endtask
  // compare the two level outputs, a settled time after the edge
  task automatic sig(input logic expIrq, input logic expWhole);
    #1;
    tests_run++;
    if (irq !== expIrq || wholeMsg !== expWhole) begin
      errors++;
      $display("MISMATCH t=%0t irq %b whole %b", $time, irq, wholeMsg);
    end
    @(posedge clock);
  endtask
  // one-cycle write, entered at a rising edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clock);
    regWr <= 1'b0;
    @(posedge clock);
  endtask
  // one-cycle read, data checked in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clock);
    regRd <= 1'b0;
    #1;
    chk8(regRdData, exp);
    @(posedge clock);
  endtask
  // one-cycle event pulse, optionally beside a status read
  task automatic pulse(input logic [7:0] v, input logic withRd, input logic [7:0] exp);
    evt <= v;
    regAddr <= `LCTS_OFF_STATUS;
    regRd <= withRd;
    @(posedge clock);
    evt <= 8'h00;
    regRd <= 1'b0;
    #1;
    if (withRd) chk8(regRdData, exp);
    @(posedge clock);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // reset values, unmapped read
  task automatic t_reset;
    rd(`LCTS_OFF_STATUS, 8'h00);
    rd(`LCTS_OFF_ENABLE, 8'h00);
    rd(`LCTS_OFF_CLEAR, 8'h00);
    rd(`LCTS_OFF_KIND, 8'h00);
    rd(4'hF, 8'h00);
    sig(1'b0, 1'b0);
  endtask
  // every event sets its own bit, buffer full sets bit 3, a read clears it
  task automatic t_events;
    for (int i = 0; i < 8; i++) begin
      pulse(8'h01 << i, 1'b0, 8'h00);
      rd(`LCTS_OFF_STATUS, (i == 7) ? 8'h08 : (8'h01 << i));
      rd(`LCTS_OFF_STATUS, 8'h00);
    end
  endtask
  // message kind shows and survives reads
  task automatic t_kind;
    rxMsgKind <= 1'b1;
    rxMsgDoneEvt <= 1'b1;
    @(posedge clock);
    rxMsgDoneEvt <= 1'b0;
    @(posedge clock);
    rd(`LCTS_OFF_STATUS, 8'h80);
    rd(`LCTS_OFF_STATUS, 8'h80);
    rd(`LCTS_OFF_KIND, 8'h01);
    rxMsgKind <= 1'b0;
    rxMsgDoneEvt <= 1'b1;
    @(posedge clock);
    rxMsgDoneEvt <= 1'b0;
    @(posedge clock);
    rd(`LCTS_OFF_STATUS, 8'h00);
  endtask
  // enables gate the interrupt, read and clear drop it
  task automatic t_irq;
    wr(`LCTS_OFF_ENABLE, 8'hFF);
    rd(`LCTS_OFF_ENABLE, 8'h7F);
    pulse(8'h40, 1'b0, 8'h00);
    sig(1'b1, 1'b0);
    rd(`LCTS_OFF_STATUS, 8'h40);
    sig(1'b0, 1'b0);
    wr(`LCTS_OFF_ENABLE, 8'h10);
    pulse(8'h40, 1'b0, 8'h00);
    sig(1'b0, 1'b0);
    pulse(8'h10, 1'b0, 8'h00);
    sig(1'b1, 1'b0);
    wr(`LCTS_OFF_CLEAR, 8'h10);
    sig(1'b0, 1'b0);
    rd(`LCTS_OFF_STATUS, 8'h40);
  endtask
  // whole message, set beside a read, write to status ignored
  task automatic t_misc;
    pulse(8'h01, 1'b0, 8'h00);
    sig(1'b0, 1'b0);
    pulse(8'h08, 1'b0, 8'h00);
    sig(1'b0, 1'b1);
    rd(`LCTS_OFF_STATUS, 8'h09);
    sig(1'b0, 1'b0);
    pulse(8'h04, 1'b1, 8'h00);
    rd(`LCTS_OFF_STATUS, 8'h04);
    wr(`LCTS_OFF_STATUS, 8'hFF);
    rd(`LCTS_OFF_STATUS, 8'h00);
  endtask
  // software answers the transmit flags as a buffer refill would
  task automatic t_tx;
    pulse(8'h40, 1'b0, 8'h00);
    rd(`LCTS_OFF_STATUS, 8'h40);
    pulse(8'h10, 1'b1, 8'h00);
    sig(1'b1, 1'b0);
    rd(`LCTS_OFF_STATUS, 8'h10);
  endtask

  // ----------------------------------------
  // verdict and run control
  // ----------------------------------------
  // print counts and verdict, then stop
  task automatic close_out;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_reset();
    t_events();
    t_kind();
    t_irq();
    t_misc();
    t_tx();
    close_out();
  end
  // watchdog, far beyond the 125 or so cycles needed
  initial begin
    repeat (5000) @(posedge clock);
    errors++;
    close_out();
  end
endmodule
`default_nettype wire
